/* File: eil_external_irq_latch.sv */
// external interrupt request latch with apb status and control
`timescale 1ns/1ps
`default_nettype none
module eil_external_irq_latch
  import eil_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external request pin, active low
  input wire logic extRequestPinN,
  // cpu side
  input wire logic vectorFetch,
  input wire logic breakState,
  output logic extRequestOne,
  output logic pinLevel,
  output logic [15:0] vectorAddrHi,
  output logic [15:0] vectorAddrLo,
  // summary interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic latch;
    logic ackSeen;
    logic maskBit;
    logic modeBit;
    logic breakClearEnable;
    logic pinPrev;
    logic [1:0] settle;
    logic [31:0] rdata;
  } eil_state_t;
  eil_state_t st_q, st_d;

  logic pinSync;
  logic [EIL_EVT_W-1:0] evtSet;
  logic [EIL_EVT_W-1:0] evtStatus;
  logic [EIL_EVT_W-1:0] evtMask;
  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic lowByteWe;
  logic mapped;
  logic ackWrite;
  logic ackAny;
  logic fallEdge;
  logic pinLow;
  logic setReq;
  logic statusClrWe;
  logic maskWe;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  eil_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pinAsync(extRequestPinN),
    .pinSync(pinSync)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign apbRead = psel && !penable && !pwrite;
  assign lowByteWe = apbWrite && pstrb[0];
  assign mapped = (paddr == EIL_STATUS_CONTROL_ADDR) ||
                  (paddr == EIL_MASK_STATUS_ADDR) ||
                  (paddr == EIL_EVENT_STATUS_ADDR) ||
                  (paddr == EIL_EVENT_MASK_ADDR) ||
                  (paddr == EIL_BREAK_CTRL_ADDR);
  assign pready = 1'b1;
  assign pslverr = apbAccess && !mapped;
  assign statusClrWe = lowByteWe && (paddr == EIL_EVENT_STATUS_ADDR);
  assign maskWe = lowByteWe && (paddr == EIL_EVENT_MASK_ADDR);

  // ----------------------------------------------------------------
  // request latch logic
  // ----------------------------------------------------------------
  assign pinLow = !pinSync;
  // synchroniser reset level is no real sample: a pin held low through reset makes no edge
  assign fallEdge = st_q.pinPrev && !pinSync && (st_q.settle == EIL_SYNC_SETTLE);
  assign ackWrite = lowByteWe && (paddr == EIL_STATUS_CONTROL_ADDR) &&
                    pwdata[EIL_ACK_BIT];
  // break protects the latch from an ack write unless clear enable is set; vectorFetch still clears it
  assign ackAny = (ackWrite && (!breakState || st_q.breakClearEnable)) ||
                  vectorFetch;
  // level mode keeps re-setting while the pin is low
  assign setReq = fallEdge || (st_q.modeBit && pinLow);

  always_comb begin
    st_d = st_q;
    st_d.pinPrev = pinSync;
    if (st_q.settle != EIL_SYNC_SETTLE) begin
      st_d.settle = st_q.settle + 2'h1;
    end
    if (lowByteWe && (paddr == EIL_STATUS_CONTROL_ADDR)) begin
      st_d.maskBit = pwdata[EIL_MASK_BIT];
      st_d.modeBit = pwdata[EIL_MODE_BIT];
    end
    if (lowByteWe && (paddr == EIL_BREAK_CTRL_ADDR)) begin
      st_d.breakClearEnable = pwdata[EIL_BCE_BIT];
    end
    if (!st_q.modeBit) begin
      if (ackAny) begin
        st_d.latch = 1'b0;
      end
      st_d.ackSeen = 1'b0;
    end else begin
      // clear once both ack and pin high happened, either order
      if (ackAny) begin
        st_d.ackSeen = 1'b1;
      end
      if ((ackAny || st_q.ackSeen) && !pinLow) begin
        st_d.latch = 1'b0;
        st_d.ackSeen = 1'b0;
      end
    end
    if (setReq) begin
      st_d.latch = 1'b1;
      if (fallEdge) begin
        st_d.ackSeen = 1'b0;
      end
    end
    // read data captured in setup so it is a register in access
    if (apbRead) begin
      unique case (paddr)
        EIL_STATUS_CONTROL_ADDR: begin
          st_d.rdata = {24'h000000, 4'h0, st_q.latch, 1'b0,
                        st_q.maskBit, st_q.modeBit};
        end
        EIL_MASK_STATUS_ADDR: begin
          st_d.rdata = {31'h00000000, pinSync};
        end
        EIL_EVENT_STATUS_ADDR: begin
          st_d.rdata = {30'h00000000, evtStatus};
        end
        EIL_EVENT_MASK_ADDR: begin
          st_d.rdata = {30'h00000000, evtMask};
        end
        EIL_BREAK_CTRL_ADDR: begin
          st_d.rdata = {31'h00000000, st_q.breakClearEnable};
        end
        default: begin
          st_d.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q.latch <= 1'b0;
      st_q.ackSeen <= 1'b0;
      st_q.maskBit <= EIL_STATUS_CONTROL_RESET[EIL_MASK_BIT];
      st_q.modeBit <= EIL_STATUS_CONTROL_RESET[EIL_MODE_BIT];
      st_q.breakClearEnable <= 1'b0;
      st_q.pinPrev <= 1'b1;
      st_q.settle <= 2'h0;
      st_q.rdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // events and outputs
  // ----------------------------------------------------------------
  assign evtSet[EIL_EVT_LATCH] = setReq && !st_q.latch;
  assign evtSet[EIL_EVT_ACK] = ackAny;

  eil_event_regs u_evt (
    .clk(clk),
    .resetn(resetn),
    .evtSet(evtSet),
    .statusClrWe(statusClrWe),
    .maskWe(maskWe),
    .wdata(pwdata[EIL_EVT_W-1:0]),
    .status(evtStatus),
    .mask(evtMask),
    .irq(irq)
  );

  assign prdata = st_q.rdata;
  assign extRequestOne = st_q.latch && !st_q.maskBit;
  assign pinLevel = pinSync;
  assign vectorAddrHi = EIL_VECTOR_HI_ADDR;
  assign vectorAddrLo = EIL_VECTOR_LO_ADDR;
endmodule : eil_external_irq_latch
`default_nettype wire

/* File: eil_pkg.sv */
// package of constants for the external interrupt latch
package eil_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [11:0] EIL_STATUS_CONTROL_IDX = 12'h01A;
  localparam logic [11:0] EIL_STATUS_CONTROL_ADDR = 12'h068;
  localparam logic [11:0] EIL_MASK_STATUS_ADDR = 12'h100;
  localparam logic [11:0] EIL_EVENT_STATUS_ADDR = 12'h104;
  localparam logic [11:0] EIL_EVENT_MASK_ADDR = 12'h108;
  localparam logic [11:0] EIL_BREAK_CTRL_ADDR = 12'h10C;
  // --------------------------------------------------------------
  // status and control fields
  // --------------------------------------------------------------
  localparam int EIL_PEND_BIT = 3;
  localparam int EIL_ACK_BIT = 2;
  localparam int EIL_MASK_BIT = 1;
  localparam int EIL_MODE_BIT = 0;
  localparam logic [7:0] EIL_STATUS_CONTROL_RESET = 8'h00;
  localparam int EIL_BCE_BIT = 0;
  // edges before both the synchroniser output and pinPrev hold real pin samples
  localparam logic [1:0] EIL_SYNC_SETTLE = 2'h3;
  // --------------------------------------------------------------
  // event bits and cpu vector addresses
  // --------------------------------------------------------------
  localparam int EIL_EVT_LATCH = 0;
  localparam int EIL_EVT_ACK = 1;
  localparam int EIL_EVT_W = 2;
  localparam logic [15:0] EIL_VECTOR_HI_ADDR = 16'hFFFA;
  localparam logic [15:0] EIL_VECTOR_LO_ADDR = 16'hFFFB;
endpackage : eil_pkg

/* File: eil_sync.sv */
// two-stage synchroniser for the request pin
`timescale 1ns/1ps
`default_nettype none
module eil_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pin in, synchronised out
  input wire logic pinAsync,
  output logic pinSync
);
  typedef struct packed {
    logic s1;
    logic s2;
  } eil_sync_t;
  eil_sync_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    st_d.s1 = pinAsync;
    st_d.s2 = st_q.s1;
  end
  // idle level of the active-low pin is high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end
  assign pinSync = st_q.s2;
endmodule : eil_sync
`default_nettype wire

/* File: eil_event_regs.sv */
// sticky event status and mask with one interrupt output
`timescale 1ns/1ps
`default_nettype none
module eil_event_regs
  import eil_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // events and software access
  input wire logic [EIL_EVT_W-1:0] evtSet,
  input wire logic statusClrWe,
  input wire logic maskWe,
  input wire logic [EIL_EVT_W-1:0] wdata,
  // state out
  output logic [EIL_EVT_W-1:0] status,
  output logic [EIL_EVT_W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [EIL_EVT_W-1:0] sts;
    logic [EIL_EVT_W-1:0] msk;
  } eil_evt_t;
  eil_evt_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    // set beats a clear in the same cycle
    if (statusClrWe) begin
      st_d.sts = st_q.sts & ~wdata;
    end
    st_d.sts = st_d.sts | evtSet;
    if (maskWe) begin
      st_d.msk = wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign status = st_q.sts;
  assign mask = st_q.msk;
  assign irq = |(st_q.sts & st_q.msk);
endmodule : eil_event_regs
`default_nettype wire

/* File: eil_latch_props.sv */
// assertion checker for the external interrupt latch
`timescale 1ns/1ps
`default_nettype none
module eil_latch_props
  import eil_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin and cpu side
  input wire logic extRequestPinN,
  input wire logic vectorFetch,
  input wire logic breakState,
  input wire logic extRequestOne,
  input wire logic pinLevel,
  input wire logic [15:0] vectorAddrHi,
  input wire logic [15:0] vectorAddrLo
);
  // ----------------------------------------
  // shadow of mask and mode from bus writes
  // ----------------------------------------
  logic wrSc;
  logic mapped;
  logic maskQ;
  logic modeQ;
  assign wrSc = psel && penable && pwrite && pstrb[0] && paddr == EIL_STATUS_CONTROL_ADDR;
  assign mapped = paddr inside {EIL_STATUS_CONTROL_ADDR, EIL_MASK_STATUS_ADDR,
    EIL_EVENT_STATUS_ADDR, EIL_EVENT_MASK_ADDR, EIL_BREAK_CTRL_ADDR};
  always_ff @(posedge clk) begin
    if (!resetn) begin
      maskQ <= 1'b0;
      modeQ <= 1'b0;
    end else if (wrSc) begin
      maskQ <= pwdata[EIL_MASK_BIT];
      modeQ <= pwdata[EIL_MODE_BIT];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  vec_pair_a: assert property (vectorAddrHi == 16'hFFFA && vectorAddrLo == 16'hFFFB)
    else $error("vector pair wrong");
  ready_high_a: assert property (psel && penable |-> pready)
    else $error("wait state seen");
  bad_addr_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error wrong");
  pin_sync_a: assert property ($past(resetn) && $past(resetn, 2)
    |-> pinLevel == $past(extRequestPinN, 2))
    else $error("pin level late");
  edge_set_a: assert property ($past(resetn) && $past(resetn, 2) && $past(resetn, 3)
    && $fell(pinLevel) && !maskQ && !wrSc |=> extRequestOne)
    else $error("edge not latched");
  level_hold_a: assert property (modeQ && !pinLevel && !maskQ && !wrSc |=> extRequestOne)
    else $error("level request dropped");
  mask_block_a: assert property (maskQ |-> !extRequestOne)
    else $error("masked request shown");
  fetch_clear_a: assert property (vectorFetch && pinLevel |=> !extRequestOne)
    else $error("fetch did not clear");
  ack_clear_a: assert property (wrSc && pwdata[EIL_ACK_BIT] && pinLevel
    && !breakState |=> !extRequestOne)
    else $error("ack did not clear");
  read_zero_a: assert property (psel && !penable && !pwrite && paddr == EIL_STATUS_CONTROL_ADDR
    |=> prdata[31:4] == 28'h0000000 && !prdata[EIL_ACK_BIT])
    else $error("reserved bits set");
endmodule : eil_latch_props
bind eil_external_irq_latch eil_latch_props chk (.clk, .resetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .extRequestPinN, .vectorFetch,
  .breakState, .extRequestOne, .pinLevel, .vectorAddrHi, .vectorAddrLo);
`default_nettype wire

/* File: eil_pin_model.sv */
// outside device driving the active-low request pin
`timescale 1ns/1ps
`default_nettype none
module eil_pin_model (
  // clock
  input wire logic clk,
  // request from bench, pin out
  input wire logic assertReq,
  output logic extRequestPinN
);
  // idles high as if pulled up; moves just after an edge
  initial extRequestPinN = 1'b1;
  always @(posedge clk) extRequestPinN <= !assertReq;
endmodule : eil_pin_model
`default_nettype wire

/* File: eil_external_irq_latch_tb.sv */
// self-checking bench for the external interrupt latch
`timescale 1ns/1ps
`default_nettype none
module eil_external_irq_latch_tb
  import eil_pkg::*;
();
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk, resetn, psel, penable, pwrite, vectorFetch, breakState, assertReq, slv;
  logic pready, pslverr, extRequestPinN, extRequestOne, pinLevel, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int errors, n_checks;
  eil_pin_model dev (.clk, .assertReq, .extRequestPinN);
  eil_external_irq_latch uut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .extRequestPinN, .vectorFetch, .breakState,
    .extRequestOne, .pinLevel, .vectorAddrHi(), .vectorAddrLo(), .irq);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one transfer, then an idle edge so strobes never toggle twice at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      report_and_stop();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdc
  task automatic pin(input logic low);
    assertReq <= low;
    cyc(5);
  endtask : pin
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_edge;
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h0);
    rdc(EIL_BREAK_CTRL_ADDR, 32'h0);
    rdc(EIL_MASK_STATUS_ADDR, 32'h1);
    rdc(12'h0F0, 32'h0);
    check(slv, 1'b1);
    pin(1'b1);
    check(extRequestOne, 1'b1);
    check(pinLevel, 1'b0);
    rdc(EIL_MASK_STATUS_ADDR, 32'h0);
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h8);
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h4);
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h0);
    pin(1'b0);
    pin(1'b1);
    check(extRequestOne, 1'b1);
    pin(1'b0);
    vectorFetch <= 1'b1;
    cyc(1);
    vectorFetch <= 1'b0;
    cyc(1);
    check(extRequestOne, 1'b0);
    $display("edge test done");
  endtask : t_edge
  task automatic t_mask;
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h2);
    pin(1'b1);
    check(extRequestOne, 1'b0);
    rdc(EIL_STATUS_CONTROL_ADDR, 32'hA);
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h0);
    check(extRequestOne, 1'b1);
    pin(1'b0);
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h4);
    check(extRequestOne, 1'b0);
    pstrb <= 4'hE;
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h2);
    pstrb <= 4'hF;
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h0);
    $display("mask test done");
  endtask : t_mask
  task automatic t_level;
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h1);
    pin(1'b1);
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h5);
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h9);
    pin(1'b0);
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h1);
    pin(1'b1);
    resetn <= 1'b0;
    cyc(2);
    check(extRequestOne, 1'b0);
    resetn <= 1'b1;
    cyc(1);
    apb(1'b0, EIL_STATUS_CONTROL_ADDR, 32'h0);
    check(rd & 32'h7, 32'h0);
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h0);
    pin(1'b0);
    $display("level test done");
  endtask : t_level
  task automatic t_break;
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h4);
    pin(1'b1);
    breakState <= 1'b1;
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h4);
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h8);
    apb(1'b1, EIL_BREAK_CTRL_ADDR, 32'h1);
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h4);
    breakState <= 1'b0;
    cyc(2);
    rdc(EIL_STATUS_CONTROL_ADDR, 32'h0);
    apb(1'b1, EIL_BREAK_CTRL_ADDR, 32'h0);
    pin(1'b0);
    $display("break test done");
  endtask : t_break
  task automatic t_irq;
    apb(1'b1, EIL_EVENT_STATUS_ADDR, 32'h3);
    apb(1'b1, EIL_EVENT_MASK_ADDR, 32'h1);
    pin(1'b1);
    check(irq, 1'b1);
    rdc(EIL_EVENT_STATUS_ADDR, 32'h1);
    apb(1'b1, EIL_EVENT_STATUS_ADDR, 32'h1);
    apb(1'b1, EIL_STATUS_CONTROL_ADDR, 32'h4);
    check(irq, 1'b0);
    rdc(EIL_EVENT_STATUS_ADDR, 32'h2);
    $display("irq test done");
  endtask : t_irq
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    vectorFetch = 1'b0;
    breakState = 1'b0;
    assertReq = 1'b0;
    errors = 0;
    n_checks = 0;
    cyc(8);
    resetn <= 1'b1;
    cyc(1);
    t_edge();
    t_mask();
    t_level();
    t_break();
    t_irq();
    report_and_stop();
  end
endmodule : eil_external_irq_latch_tb
`default_nettype wire
